/* File: src/mrf_pkg.sv */
package mrf_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [11:0] RX_ACCEPT_IDX = 12'h0104;
	localparam logic [11:0] TX_IRQ_EN_IDX = 12'h0106;
	localparam logic [11:0] STATION_0_IDX = 12'h0158;
	localparam logic [11:0] STATION_1_IDX = 12'h015A;
	localparam logic [11:0] STATION_2_IDX = 12'h015C;

	// identifier fields and reset values
	localparam logic [15:0] RX_ACCEPT_ID = 16'h0005;
	localparam logic [15:0] TX_IRQ_EN_ID = 16'h0007;
	localparam logic [15:0] RX_ACCEPT_RST = 16'h0005;
	localparam logic [15:0] TX_IRQ_EN_RST = 16'h0007;
	localparam logic [15:0] STATION_RST = 16'h0000;
	localparam logic [15:0] RX_ACCEPT_WMASK = 16'h7FC0;
	localparam logic [15:0] TX_IRQ_EN_WMASK = 16'hFF00;

	// receive acceptance control bit positions
	localparam int ACC_HASH_UNI = 6;
	localparam int ACC_EVERY = 7;
	localparam int ACC_GOOD = 8;
	localparam int ACC_HASH_GRP = 9;
	localparam int ACC_EXACT = 10;
	localparam int ACC_ALL_ONES = 11;
	localparam int ACC_BAD_CRC = 12;
	localparam int ACC_SHORT = 13;
	localparam int ACC_OVERSIZE = 14;

	// transmit interrupt enable bit positions
	localparam int IE_TX_DONE = 8;
	localparam int IE_LATE_COLL = 9;
	localparam int IE_OVERLONG = 10;
	localparam int IE_COLL_SEEN = 11;
	localparam int IE_RETRY_LO = 12;
	localparam int IE_RETRY_HI = 15;

	// frame length limits in bytes
	localparam logic [10:0] LEN_TINY = 11'h0008;
	localparam logic [10:0] LEN_MIN = 11'h0040;
	localparam logic [10:0] LEN_MAX = 11'h05EE;
	localparam logic [47:0] ALL_ONES_DEST = 48'hFFFF_FFFF_FFFF;
	localparam int GROUP_BIT = 40;

	// collision and jabber limits
	localparam logic [4:0] RETRY_LIMIT = 5'h10;
	localparam int CLK_HZ = 10_000_000;
	localparam int JABBER_MS = 26;
	localparam int JABBER_CYCLES = (CLK_HZ / 1000) * JABBER_MS;

	// receive frame status from the receive engine, valid with done
	typedef struct packed {
		logic done;
		logic [47:0] dest;
		logic hash_hit;
		logic crc_ok;
		logic [10:0] length;
	} mrf_rx_frame_type;

	// transmit events from the transmit engine
	typedef struct packed {
		logic active;
		logic collision;
		logic late_collision;
		logic packet_end;
	} mrf_tx_event_type;

	// optional initial values from the configuration eeprom
	typedef struct packed {
		logic load;
		logic [15:0] rx_accept;
		logic [15:0] tx_irq_en;
	} mrf_eeprom_type;
endpackage

/* File: src/mrf_config.sv */
// Behaviour
// - receive acceptance control reads 000101 in bits 5:0
// - bit 6 accepts unicast destinations passing the hash filter
// - bit 7 accepts every destination
// - bit 8 accepts good-CRC frames of 64 to 1518 bytes
// - bit 9 accepts multicast destinations passing the hash filter
// - bit A accepts exact match with the six-byte station address
// - bit B accepts the all-ones broadcast destination
// - bit C accepts address-passing bad-CRC frames, else discards them
// - bit D accepts address-passing frames under 64 bytes
// - frames under 8 bytes are always discarded
// - bit E accepts oversize frames truncated to 1518, else discards
// - receive acceptance control resets to 0x0005
// - reset values stay unless an eeprom is present and loads
// - transmit interrupt enables read 000111 in bits 5:0
// - bit 8 interrupts on completed transmit; clear enables suppress
// - late collision forces bad CRC, terminates, interrupts if bit 9
// - bit A interrupts when transmit exceeds about 26 ms
// - bit B interrupts at packet end if any collision happened
// - sixteen collisions abandon packet; bits F:C enable interrupt
// - transmit interrupt enables reset to 0x0007
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module mrf_config #(
	parameter int JABBER_LIMIT = mrf_pkg::JABBER_CYCLES
) (
	input wire logic core_clk_in, // 10 MHz system clock
	input wire logic nrst_in, // async reset, active low
	input wire logic ce_in, // clock enable, freezes state when low
	input wire logic [11:0] avs_address_in, // avalon byte address
	input wire logic avs_read_in, // avalon read
	input wire logic avs_write_in, // avalon write
	input wire logic [31:0] avs_writedata_in, // avalon write data
	input wire logic [3:0] avs_byteenable_in, // avalon byte enables
	output logic [31:0] avs_readdata_out, // avalon read data
	output logic avs_waitrequest_out, // avalon wait request
	input wire logic eeprom_present_in, // configuration eeprom found
	input wire mrf_pkg::mrf_eeprom_type eeprom_in, // eeprom load
	input wire mrf_pkg::mrf_rx_frame_type rx_frame_in, // frame status
	input wire mrf_pkg::mrf_tx_event_type tx_event_in, // tx events
	output logic rx_verdict_out, // pulse: verdict valid
	output logic rx_accept_out, // frame kept, with verdict
	output logic rx_truncate_out, // keep first 1518 bytes only
	output logic tx_force_bad_crc_out, // pulse: corrupt CRC
	output logic tx_terminate_out, // pulse: stop transmission now
	output logic tx_abandon_out, // pulse: drop packet, no retry
	output logic tx_irq_out // pulse: enabled transmit interrupt
);
	import mrf_pkg::*;

	logic [15:0] rx_acc_q;
	logic [15:0] tx_ie_q;
	logic [47:0] station_q;
	logic wait_q;
	logic [15:0] rd_d;
	logic [11:0] idx;
	logic [15:0] wdata;
	logic [15:0] wmask;
	logic wr_now;

	// register index is the byte address over four
	assign idx = {2'b00, avs_address_in[11:2]};
	assign wdata = avs_writedata_in[15:0];
	assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign wr_now = avs_write_in & ~wait_q;

	// read mux; identifier bits are constant, unmapped words read zero
	always_comb begin
		rd_d = 16'h0000;
		case (idx)
			RX_ACCEPT_IDX: rd_d = (rx_acc_q & RX_ACCEPT_WMASK) | RX_ACCEPT_ID;
			TX_IRQ_EN_IDX: rd_d = (tx_ie_q & TX_IRQ_EN_WMASK) | TX_IRQ_EN_ID;
			STATION_0_IDX: rd_d = station_q[47:32];
			STATION_1_IDX: rd_d = station_q[31:16];
			STATION_2_IDX: rd_d = station_q[15:0];
			default: rd_d = 16'h0000;
		endcase
	end

	// bus handshake: one wait cycle, then a single cycle with wait low
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_q <= 1'b1;
			avs_readdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			if ((avs_read_in | avs_write_in) & wait_q) begin
				wait_q <= 1'b0;
				avs_readdata_out <= {16'h0000, rd_d};
			end else begin
				wait_q <= 1'b1;
			end
		end
	end
	assign avs_waitrequest_out = wait_q;

	// configuration registers; eeprom load only counts when one is present
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_acc_q <= RX_ACCEPT_RST;
			tx_ie_q <= TX_IRQ_EN_RST;
			station_q <= {STATION_RST, STATION_RST, STATION_RST};
		end else if (ce_in) begin
			if (eeprom_in.load & eeprom_present_in) begin
				rx_acc_q <= eeprom_in.rx_accept;
				tx_ie_q <= eeprom_in.tx_irq_en;
			end else if (wr_now) begin
				case (idx)
					RX_ACCEPT_IDX: rx_acc_q <= (rx_acc_q & ~wmask) | (wdata & wmask);
					// reserved 7:6 are masked at readback, so stray ones do no harm
					TX_IRQ_EN_IDX: tx_ie_q <= (tx_ie_q & ~wmask) | (wdata & wmask);
					STATION_0_IDX: station_q[47:32] <= (station_q[47:32] & ~wmask) | (wdata & wmask);
					STATION_1_IDX: station_q[31:16] <= (station_q[31:16] & ~wmask) | (wdata & wmask);
					STATION_2_IDX: station_q[15:0] <= (station_q[15:0] & ~wmask) | (wdata & wmask);
					default: ;
				endcase
			end
		end
	end

	// destination filter terms
	logic is_group;
	logic is_all_ones;
	logic addr_pass;
	logic len_tiny;
	logic len_short;
	logic len_over;
	logic frame_good;
	logic status_ok;
	logic accept_d;

	assign is_all_ones = rx_frame_in.dest == ALL_ONES_DEST;
	assign is_group = rx_frame_in.dest[GROUP_BIT];
	assign addr_pass = rx_acc_q[ACC_EVERY]
		| (rx_acc_q[ACC_HASH_UNI] & rx_frame_in.hash_hit & ~is_group)
		| (rx_acc_q[ACC_HASH_GRP] & rx_frame_in.hash_hit & is_group)
		| (rx_acc_q[ACC_EXACT] & (rx_frame_in.dest == station_q))
		| (rx_acc_q[ACC_ALL_ONES] & is_all_ones);

	// length and checksum classes; a frame may be bad in more than one way
	assign len_tiny = rx_frame_in.length < LEN_TINY;
	assign len_short = rx_frame_in.length < LEN_MIN;
	assign len_over = rx_frame_in.length > LEN_MAX;
	assign frame_good = rx_frame_in.crc_ok & ~len_short & ~len_over;
	always_comb begin
		status_ok = 1'b1;
		if (frame_good) begin
			status_ok = rx_acc_q[ACC_GOOD];
		end else begin
			if (!rx_frame_in.crc_ok) begin
				status_ok = status_ok & rx_acc_q[ACC_BAD_CRC];
			end
			if (len_short) begin
				status_ok = status_ok & rx_acc_q[ACC_SHORT];
			end
			if (len_over) begin
				status_ok = status_ok & rx_acc_q[ACC_OVERSIZE];
			end
		end
	end
	assign accept_d = addr_pass & status_ok & ~len_tiny;

	// one verdict per finished frame, registered
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_verdict_out <= 1'b0;
			rx_accept_out <= 1'b0;
			rx_truncate_out <= 1'b0;
		end else if (ce_in) begin
			rx_verdict_out <= rx_frame_in.done;
			if (rx_frame_in.done) begin
				rx_accept_out <= accept_d;
				rx_truncate_out <= accept_d & len_over;
			end
		end
	end

	// transmit watch: collision count and jabber timer per packet
	logic [4:0] coll_q;
	logic [31:0] jab_q;
	logic jab_hit;
	logic retry_hit;
	logic retry_en;

	assign retry_en = |tx_ie_q[IE_RETRY_HI:IE_RETRY_LO];
	assign retry_hit = tx_event_in.collision & (coll_q == RETRY_LIMIT - 5'h01);
	assign jab_hit = tx_event_in.active & (jab_q == JABBER_LIMIT - 1);

	// count normal collisions; cleared at packet end or at abandon
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			coll_q <= 5'h00;
		end else if (ce_in) begin
			if (tx_event_in.packet_end | retry_hit) begin
				coll_q <= 5'h00;
			end else if (tx_event_in.collision) begin
				coll_q <= coll_q + 5'h01;
			end
		end
	end

	// jabber timer runs while transmitting and parks at the limit
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			jab_q <= 32'h0000_0000;
		end else if (ce_in) begin
			if (!tx_event_in.active) begin
				jab_q <= 32'h0000_0000;
			end else if (jab_q < JABBER_LIMIT) begin
				jab_q <= jab_q + 32'h0000_0001;
			end
		end
	end

	// transmit actions and the gated interrupt pulse
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_force_bad_crc_out <= 1'b0;
			tx_terminate_out <= 1'b0;
			tx_abandon_out <= 1'b0;
			tx_irq_out <= 1'b0;
		end else if (ce_in) begin
			tx_force_bad_crc_out <= tx_event_in.late_collision;
			tx_terminate_out <= tx_event_in.late_collision | jab_hit;
			tx_abandon_out <= retry_hit;
			tx_irq_out <= (tx_ie_q[IE_TX_DONE] & tx_event_in.packet_end)
				| (tx_ie_q[IE_LATE_COLL] & tx_event_in.late_collision)
				| (tx_ie_q[IE_OVERLONG] & jab_hit)
				| (tx_ie_q[IE_COLL_SEEN] & tx_event_in.packet_end
					& (coll_q != 5'h00))
				| (retry_en & retry_hit);
		end
	end

	// checks
	sequence req_seen_s;
		(avs_read_in | avs_write_in) & avs_waitrequest_out & ce_in;
	endsequence
	sequence ack_next_s;
		##1 !avs_waitrequest_out;
	endsequence

	property bus_ack_p;
		@(posedge core_clk_in) disable iff (!nrst_in)
		req_seen_s |-> ack_next_s;
	endproperty
	bus_ack_a: assert property (bus_ack_p)
		else $error("no acknowledge one cycle after request");

	rx_ident_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(avs_read_in & ce_in & wait_q & idx == RX_ACCEPT_IDX) |=>
		avs_readdata_out[5:0] == RX_ACCEPT_ID[5:0])
		else $error("receive control identifier wrong");
	tx_ident_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(avs_read_in & ce_in & wait_q & idx == TX_IRQ_EN_IDX) |=>
		avs_readdata_out[5:0] == TX_IRQ_EN_ID[5:0])
		else $error("transmit enable identifier wrong");
	tiny_drop_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & rx_frame_in.done & len_tiny) |=> !rx_accept_out)
		else $error("frame under eight bytes accepted");
	every_dest_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & rx_frame_in.done & rx_acc_q[ACC_EVERY] & frame_good
		& rx_acc_q[ACC_GOOD]) |=> rx_accept_out)
		else $error("promiscuous good frame dropped");
	need_addr_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & rx_frame_in.done & !addr_pass) |=> !rx_accept_out)
		else $error("frame accepted without address pass");
	bad_crc_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & rx_frame_in.done & !rx_frame_in.crc_ok
		& !rx_acc_q[ACC_BAD_CRC]) |=> !rx_accept_out)
		else $error("bad checksum frame accepted while disabled");
	oversize_cut_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & rx_frame_in.done & accept_d & len_over) |=>
		rx_truncate_out & rx_accept_out)
		else $error("accepted oversize frame not truncated");
	late_coll_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & tx_event_in.late_collision) |=>
		tx_force_bad_crc_out & tx_terminate_out
		& (tx_irq_out == $past(tx_ie_q[IE_LATE_COLL]) | tx_irq_out))
		else $error("late collision not terminated");
	retry_stop_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & tx_event_in.collision & coll_q == 5'h0F) |=>
		tx_abandon_out & coll_q == 5'h00)
		else $error("sixteenth collision not abandoned");
	irq_quiet_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(ce_in & tx_ie_q[15:8] == 8'h00 & !eeprom_in.load) |=> !tx_irq_out)
		else $error("interrupt raised with all enables clear");
endmodule
`default_nettype wire

/* File: testbench/mrf_medium.sv */
`timescale 1ns/1ns
`default_nettype none
// stands in for the receive and transmit engines on the wire side
module mrf_medium
	import mrf_pkg::*;
(
	input wire logic clk_in, // system clock
	output var mrf_pkg::mrf_rx_frame_type rx_out, // frame status
	output var mrf_pkg::mrf_tx_event_type tx_out // transmit events
);
	initial begin
		rx_out = '0;
		tx_out = '0;
	end
	// one status word per frame, done for a single cycle after a gap
	task automatic frame(input logic [47:0] d, input logic h, c,
		input logic [10:0] n, input int gap);
		repeat (gap + 1) @(posedge clk_in);
		rx_out <= {1'b1, d, h, c, n};
		@(posedge clk_in);
		// fields are only valid with done, so scramble them afterwards
		rx_out <= {1'b0, ~d, ~h, ~c, ~n};
	endtask
	// pulses last one cycle; active stays up for cyc cycles
	task automatic ev_pulse(input logic [3:0] e, input int cyc);
		@(posedge clk_in);
		tx_out <= e;
		@(posedge clk_in);
		// a single-cycle event must not assign tx_out twice in one step
		if (cyc > 1) begin
			tx_out <= {e[3], 3'b000};
			repeat (cyc - 1) @(posedge clk_in);
		end
		tx_out <= '0;
	endtask
endmodule
`default_nettype wire

/* File: testbench/tb_mac_rx_filter_tx_irq_config.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_mac_rx_filter_tx_irq_config;
	import mrf_pkg::*;
	localparam int JAB = 50; // short jabber limit keeps the run brief
	logic clk, nrst_n, rd, wr, verdict, acc, trunc, fbc, term, drop, irq;
	logic eep_pres, waitreq, ce;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [3:0] be;
	logic [15:0] ctl, ie;
	logic [47:0] sta;
	mrf_eeprom_type eep;
	mrf_rx_frame_type rxf;
	mrf_tx_event_type txe;
	int fails, comparisons, n_irq, n_term, n_bad, n_drop;
	mrf_config #(.JABBER_LIMIT(JAB)) u_dut (.core_clk_in(clk),
		.nrst_in(nrst_n), .ce_in(ce), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .eeprom_present_in(eep_pres),
		.eeprom_in(eep), .rx_frame_in(rxf), .tx_event_in(txe),
		.rx_verdict_out(verdict), .rx_accept_out(acc),
		.rx_truncate_out(trunc), .tx_force_bad_crc_out(fbc),
		.tx_terminate_out(term), .tx_abandon_out(drop), .tx_irq_out(irq));
	mrf_medium u_medium (.clk_in(clk), .rx_out(rxf), .tx_out(txe));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// transmit pulses are counted, so one late by a cycle still shows
	always @(posedge clk) begin
		n_irq <= n_irq + int'(irq === 1'b1);
		n_term <= n_term + int'(term === 1'b1);
		n_bad <= n_bad + int'(fbc === 1'b1);
		n_drop <= n_drop + int'(drop === 1'b1);
	end
	task automatic chk(input string s, input logic [15:0] e, got);
		comparisons++;
		if (got !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, got);
		end
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {16'($urandom), d};
		be <= {2'($urandom), 2'b11};
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 40);
		if (n >= 40) fails++;
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [15:0] e,
		input string s);
		bus(1'b0, a, 16'h0000);
		chk(s, e, q[15:0]);
		chk("upper half", 16'h0000, q[31:16]);
	endtask
	task automatic eeprom(input logic [15:0] r, t);
		@(posedge clk);
		eep <= {1'b1, r, t};
		@(posedge clk);
		eep <= '0;
	endtask
	task automatic do_reset();
		@(posedge clk);
		nrst_n <= 1'b0;
		repeat (8) @(posedge clk);
		nrst_n <= 1'b1;
	endtask
	// reference verdict: {accept, truncate}
	function automatic logic [1:0] judge(logic [47:0] d, logic h, c,
		logic [10:0] n);
		logic pass, ok;
		pass = ctl[7] | ctl[6] & h & !d[40] | ctl[9] & h & d[40]
			| ctl[10] & (d == sta) | ctl[11] & (d == '1);
		if (c && n >= 64 && n <= 1518) ok = ctl[8];
		else ok = (c | ctl[12]) & (n >= 64 | ctl[13]) & (n <= 1518 | ctl[14]);
		ok = pass & ok & (n >= 8);
		return {ok, ok & (n > 1518)};
	endfunction
	task automatic txrun(input logic [3:0] e, input int cyc,
		input logic i, b, t, a);
		@(negedge clk);
		{n_irq, n_term, n_bad, n_drop} = '0;
		u_medium.ev_pulse(e, cyc);
		repeat (3) @(negedge clk);
		chk("tx irq", 16'(i), 16'(n_irq));
		chk("bad crc", 16'(b), 16'(n_bad));
		chk("terminate", 16'(t), 16'(n_term));
		chk("abandon", 16'(a), 16'(n_drop));
	endtask
	task automatic final_report();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#3_000_000;
		fails++;
		final_report();
	end
	initial begin
		int r;
		logic [47:0] d;
		logic [1:0] v;
		logic h, c;
		logic [10:0] n;
		logic [10:0] lens[8] = '{4, 7, 8, 63, 64, 1518, 1519, 2000};
		logic [15:0] tv[8] = '{16'h0000, 16'h0100, 16'h0200, 16'h0400,
			16'h0800, 16'h1000, 16'h8000, 16'hFF00};
		r = $urandom(87);
		{nrst_n, rd, wr, eep_pres} = '0;
		{n_irq, n_term, n_bad, n_drop, fails, comparisons} = '0;
		addr = '0;
		wdata = '0;
		be = 4'hF;
		eep = '0;
		ce = 1'b1;
		repeat (8) @(posedge clk);
		nrst_n <= 1'b1;
		rchk(12'h410, 16'h0005, "rx control reset");
		rchk(12'h418, 16'h0007, "tx enables reset");
		rchk(12'h7FC, 16'h0000, "unmapped");
		eeprom(16'h3FFF, 16'hFF00);
		rchk(12'h410, 16'h0005, "rx without eeprom");
		eep_pres <= 1'b1;
		eeprom(16'h0F40, 16'h0100);
		rchk(12'h410, 16'h0F45, "rx from eeprom");
		rchk(12'h418, 16'h0107, "tx from eeprom");
		eep_pres <= 1'b0;
		do_reset();
		rchk(12'h410, 16'h0005, "rx second reset");
		rchk(12'h418, 16'h0007, "tx second reset");
		// a load seen while the clock enable is low must leave no trace
		ce <= 1'b0;
		eep_pres <= 1'b1;
		eeprom(16'h0F40, 16'h0100);
		ce <= 1'b1;
		eep_pres <= 1'b0;
		rchk(12'h410, 16'h0005, "rx frozen by enable");
		$display("test reset_eeprom done");
		bus(1'b1, 12'h410, 16'hFFFF);
		rchk(12'h410, 16'h7FC5, "rx all ones");
		bus(1'b1, 12'h418, 16'hFF3F);
		rchk(12'h418, 16'hFF07, "tx all ones");
		sta = {16'($urandom), 32'($urandom)};
		bus(1'b1, 12'h560, sta[47:32]);
		bus(1'b1, 12'h568, sta[31:16]);
		bus(1'b1, 12'h570, sta[15:0]);
		rchk(12'h568, sta[31:16], "station");
		$display("test registers done");
		// random filter settings against random frames
		for (int i = 0; i < 160; i++) begin
			if (i % 4 == 0) begin
				ctl = 16'($urandom) & 16'h7FC0;
				bus(1'b1, 12'h410, ctl);
			end
			case ($urandom % 4)
				0: d = sta;
				1: d = '1;
				default: d = {16'($urandom), 32'($urandom)};
			endcase
			h = 1'($urandom);
			c = 1'($urandom);
			n = lens[$urandom % 8];
			v = judge(d, h, c, n);
			u_medium.frame(d, h, c, n, int'($urandom % 3));
			@(negedge clk);
			chk("verdict", 16'h0001, 16'(verdict));
			chk("accept", 16'(v[1]), 16'(acc));
			chk("truncate", 16'(v[0]), 16'(trunc));
		end
		$display("test receive filter done");
		for (int i = 0; i < 8; i++) begin
			ie = tv[i];
			bus(1'b1, 12'h418, ie);
			txrun(4'b1001, 1, ie[8], 1'b0, 1'b0, 1'b0);
			repeat (3) u_medium.ev_pulse(4'b1100, 1);
			txrun(4'b1001, 1, ie[8] | ie[11], 1'b0, 1'b0, 1'b0);
			txrun(4'b1010, 1, ie[9], 1'b1, 1'b1, 1'b0);
			repeat (15) u_medium.ev_pulse(4'b1100, 1);
			txrun(4'b1100, 1, |ie[15:12], 1'b0, 1'b0, 1'b1);
			txrun(4'b1000, 2 * JAB + 10, ie[10], 1'b0, 1'b1, 1'b0);
		end
		$display("test transmit interrupts done");
		final_report();
	end
endmodule
`default_nettype wire
